/* bench/fbg_line_peer.sv */
`timescale 1ns/1ps
// Remote receiver on the line; it samples each bit in its middle.
module fbg_line_peer (
  input wire logic clk_in, // Clock shared with the device.
  input wire logic line_in, // Serial line.
  input wire logic [15:0] bit_clks_in, // Clocks per bit.
  input wire logic [3:0] nbits_in, // Bits between start and stop.
  output logic [15:0] word_out, // Start first, stop last.
  output logic [15:0] frames_out // Frames seen.
);
  int i;
  // Sampling on the falling clock edge keeps clear of line updates.
  initial begin
    word_out = 16'h0000;
    frames_out = 16'h0000;
    forever begin
      @(negedge line_in);
      repeat (bit_clks_in / 2) @(negedge clk_in);
      word_out = 16'h0000;
      for (i = 0; i < nbits_in + 2; i++) begin
        word_out[i] = line_in;
        if (i < nbits_in + 1) begin
          repeat (bit_clks_in) @(negedge clk_in);
        end
      end
      frames_out = frames_out + 16'h0001;
    end
  end
endmodule

/* bench/fbg_uart_tx_assertions.sv */
`timescale 1ns/1ps
// Port-level checks of the register port and the serial line.
module fbg_uart_tx_assertions #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic clk_sys_in, // Clock.
  input wire logic reset_n_in, // Reset, active low.
  input wire logic [2:0] addr_in, // Address.
  input wire logic [7:0] wr_data_in, // Write data.
  input wire logic wr_en_in, // Write strobe.
  input wire logic rd_en_in, // Read strobe.
  input wire logic [7:0] rd_data_out, // Read data.
  input wire logic txd_out, // Serial line.
  input wire logic sample_tick_out, // Sampling tick.
  input wire logic tx_empty_out // Transmitter empty.
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Named decodes keep the properties short.
  wire rd_stat = rd_en_in && addr_in == fbg_pkg::OFS_LINE_STATUS;
  wire wr_hold = wr_en_in && addr_in == fbg_pkg::OFS_TX_HOLD;
  wire rd_hold = rd_en_in && addr_in == fbg_pkg::OFS_TX_HOLD;
  AST_HOLD_READS_ZERO: assert property (
    rd_hold |=> rd_data_out == 8'h00) else $error("holding read not zero");
  AST_STATUS_EMPTY: assert property (
    rd_stat |=> rd_data_out[6] == tx_empty_out)
    else $error("status bit 6 disagrees with empty flag");
  AST_STATUS_ORDER: assert property (
    rd_stat |=> !rd_data_out[6] || rd_data_out[5])
    else $error("shifter empty without holding empty");
  AST_IDLE_HIGH: assert property (
    tx_empty_out |-> txd_out) else $error("line low while empty");
  AST_SHIFT_ON_TICK: assert property (
    $changed(txd_out) |-> $past(sample_tick_out))
    else $error("line changed without a sampling tick");
  AST_LOAD_BUSY: assert property (
    wr_hold |-> ##2 !tx_empty_out) else $error("write left it empty");
  AST_EMPTY_ENDS_HIGH: assert property (
    $rose(tx_empty_out) |-> txd_out && $past(txd_out))
    else $error("empty rose off a stop bit");
  AST_START_BUSY: assert property (
    $fell(txd_out) |-> !tx_empty_out) else $error("start while empty");
  // Main scenarios of the bench.
  cover property ($fell(txd_out));
  cover property ($rose(tx_empty_out));
  cover property (rd_stat ##1 rd_data_out[5] && !rd_data_out[6]);
endmodule

bind fbg_uart_tx fbg_uart_tx_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in),
  .addr_in(addr_in),
  .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out),
  .txd_out(txd_out),
  .sample_tick_out(sample_tick_out),
  .tx_empty_out(tx_empty_out)
);

/* bench/fbg_uart_tx_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); \
  end \
end
module fbg_uart_tx_tb;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [7:0] rd_data_out;
  logic txd_out;
  logic sample_tick_out;
  logic tx_empty_out;
  logic [15:0] p_clks = 16'h0010;
  logic [3:0] p_bits = 4'h8;
  logic [15:0] p_word;
  logic [15:0] p_frames;
  int err_total = 0;
  int checks_done = 0;
  fbg_uart_tx dut_u (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .txd_out(txd_out),
    .sample_tick_out(sample_tick_out),
    .tx_empty_out(tx_empty_out)
  );
  fbg_line_peer peer_u (
    .clk_in(clk_sys_in),
    .line_in(txd_out),
    .bit_clks_in(p_clks),
    .nbits_in(p_bits),
    .word_out(p_word),
    .frames_out(p_frames)
  );
  // A 40 ns period gives the 25 MHz system clock.
  always #20 clk_sys_in = ~clk_sys_in;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bus cycles are one strobe cycle each, changed just after an edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1;
    `CHK(rd_data_out, e)
  endtask
  task automatic wait_tick();
    do begin
      @(posedge clk_sys_in);
      #1;
    end while (sample_tick_out !== 1'b1);
  endtask
  task automatic setdiv(input logic [15:0] n, input logic [7:0] f,
                        input logic p);
    wr(fbg_pkg::OFS_DIV_LOW, n[7:0]);
    wr(fbg_pkg::OFS_DIV_HIGH, n[15:8]);
    wr(fbg_pkg::OFS_DIV_FRAC, f);
    wr(fbg_pkg::OFS_MODEM_CTRL, {p, 7'h00});
    // The old divisor may still run one period; let two ticks pass.
    repeat (2) wait_tick();
  endtask
  task automatic t_reset();
    rdchk(fbg_pkg::OFS_DIV_LOW, 8'h01);
    rdchk(fbg_pkg::OFS_DIV_HIGH, 8'h00);
    rdchk(fbg_pkg::OFS_DIV_FRAC, 8'h00);
    rdchk(fbg_pkg::OFS_LINE_STATUS, 8'h60);
    rdchk(fbg_pkg::OFS_TX_HOLD, 8'h00);
    rdchk(3'h7, 8'h00);
    wr(fbg_pkg::OFS_DIV_LOW, 8'hA6);
    wr(fbg_pkg::OFS_DIV_HIGH, 8'h0E);
    wr(fbg_pkg::OFS_DIV_FRAC, 8'h2F);
    rdchk(fbg_pkg::OFS_DIV_LOW, 8'hA6);
    rdchk(fbg_pkg::OFS_DIV_HIGH, 8'h0E);
    rdchk(fbg_pkg::OFS_DIV_FRAC, 8'h2F);
    $display("test reset done");
  endtask
  // Sixteen periods hold exactly frac stretches, whatever the start.
  task automatic t_rate(input logic [15:0] n, input logic [3:0] f,
                        input logic p);
    int c;
    int k;
    setdiv(n, {4'h0, f}, p);
    c = 0;
    k = 1;
    while (k < 17) begin
      @(posedge clk_sys_in);
      #1;
      c++;
      if (sample_tick_out === 1'b1) k++;
    end
    `CHK(c, (p ? 4 : 1) * (16 * n + f))
    $display("test rate %0h.%0h done", n, f);
  endtask
  // The line control byte picks word length, parity and stop bits.
  task automatic t_frame(input logic [1:0] m, input logic [7:0] n,
                         input logic p, input logic [7:0] lc,
                         input logic [7:0] b);
    int bc;
    int c;
    int wl;
    int nb;
    int i;
    longint t0;
    logic [15:0] fr;
    logic [15:0] ex;
    bc = (p ? 4 : 1) * n * (m == fbg_pkg::MODE_8X ? 8 :
         m == fbg_pkg::MODE_4X ? 4 : 16);
    wl = 5 + lc[1:0];
    nb = 1 + wl + lc[3] + (lc[2] ? 2 : 1);
    ex = 16'h0000;
    for (i = 0; i < wl; i++) ex[i + 1] = b[i];
    if (lc[3]) ex[wl + 1] = lc[4] ? ^ex : ~^ex;
    ex[wl + 1 + lc[3]] = 1'b1;
    setdiv({8'h00, n}, {2'b00, m, 4'h0}, p);
    wr(fbg_pkg::OFS_LINE_CTRL, lc);
    p_clks = bc[15:0];
    p_bits = wl[3:0] + {3'b000, lc[3]};
    fr = p_frames;
    wr(fbg_pkg::OFS_TX_HOLD, b);
    @(negedge txd_out);
    #1;
    t0 = $time;
    `CHK(tx_empty_out, 1'b0)
    c = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      c++;
    end while (txd_out !== 1'b1);
    `CHK(c, bc)
    rdchk(fbg_pkg::OFS_LINE_STATUS, 8'h20);
    wait (p_frames == fr + 16'h0001);
    `CHK(p_word, ex)
    do begin
      @(posedge clk_sys_in);
      #1;
    end while (tx_empty_out !== 1'b1);
    // The empty flag trails the end of the last stop bit by one clock.
    `CHK(($time - t0) / 40, nb * bc + 1)
    rdchk(fbg_pkg::OFS_LINE_STATUS, 8'h60);
    $display("test frame mode %0h done", m);
  endtask
  // A full FIFO drops further bytes; one more byte sits in the shifter.
  task automatic t_full();
    logic [15:0] fr;
    int i;
    setdiv(16'h0001, 8'h00, 1'b0);
    wr(fbg_pkg::OFS_LINE_CTRL, 8'h03);
    p_clks = 16'h0010;
    p_bits = 4'h8;
    fr = p_frames;
    for (i = 0; i < fbg_pkg::TX_FIFO_DEPTH + 2; i++) begin
      wr(fbg_pkg::OFS_TX_HOLD, i[7:0]);
    end
    do begin
      @(posedge clk_sys_in);
      #1;
    end while (tx_empty_out !== 1'b1);
    `CHK(p_frames - fr, fbg_pkg::TX_FIFO_DEPTH + 1)
    `CHK(p_word, {6'h00, 1'b1, 8'h40, 1'b0})
    $display("test full done");
  endtask
  // Two bytes written back to back leave in write order.
  task automatic t_b2b();
    logic [15:0] fr;
    setdiv(16'h0001, 8'h00, 1'b0);
    wr(fbg_pkg::OFS_LINE_CTRL, 8'h03);
    p_clks = 16'h0010;
    p_bits = 4'h8;
    fr = p_frames;
    wr(fbg_pkg::OFS_TX_HOLD, 8'hA5);
    wr(fbg_pkg::OFS_TX_HOLD, 8'h3C);
    wait (p_frames == fr + 16'h0001);
    `CHK(p_word, {6'h00, 1'b1, 8'hA5, 1'b0})
    wait (p_frames == fr + 16'h0002);
    `CHK(p_word, {6'h00, 1'b1, 8'h3C, 1'b0})
    $display("test back to back done");
  endtask
  // Main sequence; the host sets every divisor before any traffic.
  initial begin
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_rate(16'h0001, 4'h0, 1'b0);
    t_rate(16'h0002, 4'h8, 1'b0);
    t_rate(16'h0003, 4'hF, 1'b0);
    t_rate(16'h0001, 4'h1, 1'b1);
    t_rate(16'h0102, 4'h0, 1'b0);
    t_rate(16'h0001, 4'hA, 1'b0);
    t_frame(fbg_pkg::MODE_16X, 8'h01, 1'b0, 8'h03, 8'hA5);
    t_frame(fbg_pkg::MODE_8X, 8'h03, 1'b0, 8'h1B, 8'hC3);
    t_frame(fbg_pkg::MODE_4X, 8'h02, 1'b1, 8'h03, 8'h81);
    t_frame(2'h3, 8'h01, 1'b0, 8'h03, 8'h5B);
    t_frame(fbg_pkg::MODE_16X, 8'h01, 1'b0, 8'h0E, 8'hD5);
    t_b2b();
    t_full();
    report_and_stop();
  end
  // The tests need about 17000 cycles; 60000 means a hang.
  initial begin
    #(40 * 60000);
    err_total++;
    report_and_stop();
  end
endmodule

/* rtl/fbg_pkg.sv */
// Shared constants and types of the fractional rate generator and transmitter.
package fbg_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_DIV_FRAC = 3'h2;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h3;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h4;
  localparam logic [2:0] OFS_TX_HOLD = 3'h5;
  localparam logic [2:0] OFS_LINE_STATUS = 3'h6;

  // Reset values.
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_FRAC = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [7:0] RST_LINE_CTRL = 8'h03;

  // Field positions.
  localparam int FRAC_LSB = 0;
  localparam int FRAC_W = 4;
  localparam int MODE_LSB = 4;
  localparam int MODE_W = 2;
  localparam int PRESCALE_BIT = 7;
  localparam int STAT_HOLD_EMPTY_BIT = 5;
  localparam int STAT_TX_EMPTY_BIT = 6;
  localparam int LCR_WLEN_LSB = 0;
  localparam int LCR_STOP_BIT = 2;
  localparam int LCR_PAR_EN_BIT = 3;
  localparam int LCR_PAR_EVEN_BIT = 4;

  // Sampling modes and generator periods per serial bit.
  localparam logic [1:0] MODE_16X = 2'h0;
  localparam logic [1:0] MODE_8X = 2'h1;
  localparam logic [1:0] MODE_4X = 2'h2;
  localparam logic [4:0] TPB_16X = 5'h10;
  localparam logic [4:0] TPB_8X = 5'h08;
  localparam logic [4:0] TPB_4X = 5'h04;

  // Last prescaler count when the prescaler bit is set; it divides by four.
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // Smallest word length in bits.
  localparam logic [3:0] WLEN_BASE = 4'h5;

  // Transmit FIFO depth, holding register included.
  localparam int TX_FIFO_DEPTH = 64;

  // Transmitter states.
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP = 5'b10000
  } fbg_tx_state_t;

  // Divisor setting as seen by the rate generator.
  typedef struct packed {
    logic [15:0] int_div;
    logic [3:0] frac;
    logic [1:0] mode;
    logic prescale;
  } fbg_div_cfg_t;

endpackage

/* rtl/fbg_uart_tx.sv */
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module fbg_uart_tx #(
  parameter int FIFO_DEPTH = fbg_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk_sys_in, // System and oscillator clock.
  input wire logic reset_n_in, // Asynchronous reset, active low.
  input wire logic [2:0] addr_in, // Register address.
  input wire logic [7:0] wr_data_in, // Register write data.
  input wire logic wr_en_in, // Write strobe, one cycle.
  input wire logic rd_en_in, // Read strobe, one cycle.
  output logic [7:0] rd_data_out, // Read data, cycle after the strobe.
  output logic txd_out, // Serial transmit line, idles high.
  output logic sample_tick_out, // Sampling clock pulse for the receiver.
  output logic tx_empty_out // Whole transmitter empty.
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // Register state.
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic [7:0] div_frac_q;
  logic [7:0] modem_ctrl_q;
  logic [7:0] line_ctrl_q;
  logic [7:0] rd_data_q;

  // Generator state.
  logic [1:0] pre_cnt_q;
  logic [16:0] gen_cnt_q;
  logic [3:0] frac_acc_q;
  logic samp_tick_q;

  // Transmitter state.
  fbg_pkg::fbg_tx_state_t state_q;
  fbg_pkg::fbg_tx_state_t state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [4:0] tick_cnt_q;
  logic [3:0] bit_idx_q;
  logic [3:0] bit_idx_d;
  logic parity_q;
  logic parity_d;
  logic txd_q;
  logic txd_d;
  logic tx_empty_q;

  // FIFO storage and pointers, one spare bit for full versus empty.
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W:0] wr_ptr_q;
  logic [PTR_W:0] rd_ptr_q;

  // Register decode.
  wire wr_low = wr_en_in && (addr_in == fbg_pkg::OFS_DIV_LOW);
  wire wr_high = wr_en_in && (addr_in == fbg_pkg::OFS_DIV_HIGH);
  wire wr_frac = wr_en_in && (addr_in == fbg_pkg::OFS_DIV_FRAC);
  wire wr_modem = wr_en_in && (addr_in == fbg_pkg::OFS_MODEM_CTRL);
  wire wr_lcr = wr_en_in && (addr_in == fbg_pkg::OFS_LINE_CTRL);
  wire wr_hold = wr_en_in && (addr_in == fbg_pkg::OFS_TX_HOLD);

  // Divisor setting gathered from the three divisor registers and the modem control prescaler bit.
  fbg_pkg::fbg_div_cfg_t cfg;
  assign cfg.int_div = {div_high_q, div_low_q};
  assign cfg.frac = div_frac_q[fbg_pkg::FRAC_LSB +: fbg_pkg::FRAC_W];
  assign cfg.mode = div_frac_q[fbg_pkg::MODE_LSB +: fbg_pkg::MODE_W];
  assign cfg.prescale = modem_ctrl_q[fbg_pkg::PRESCALE_BIT];

  // Prescaler: a tick every clock, or every fourth clock when selected.
  wire pre_tick = !cfg.prescale
      || (pre_cnt_q == fbg_pkg::PRESCALE_LAST);

  // A zero integer divisor would stall the generator; it counts as one.
  wire [15:0] int_eff = (cfg.int_div == 16'h0000) ? 16'h0001 : cfg.int_div;

  // Fraction accumulator: its carry marks the periods to stretch, so that
  // frac of every sixteen periods are one tick longer, evenly spread.
  wire [4:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, cfg.frac};
  wire stretch = frac_sum[4];
  wire gen_end = pre_tick && (gen_cnt_q <= 17'h0_0001);
  // The reload reads the live registers only at a period boundary, so a
  // divisor write never cuts a period short or makes a runt tick; a prescaler bit write changes the count rate at once.
  wire [16:0] gen_reload = {1'b0, int_eff}
      + {16'h0000, stretch};

  // Generator periods per serial bit from the sampling mode.
  logic [4:0] tpb;
  always_comb begin
    case (cfg.mode)
      fbg_pkg::MODE_8X: tpb = fbg_pkg::TPB_8X;
      fbg_pkg::MODE_4X: tpb = fbg_pkg::TPB_4X;
      default: tpb = fbg_pkg::TPB_16X;
    endcase
  end

  // Prescaler counter runs free; its phase does not matter to the host.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_cnt_q <= 2'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
    end
  end

  // Rate generator down counter; stretched periods give the jitter of
  // one sixteenth (8X) or one eighth (4X) of a bit for odd fractions.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gen_cnt_q <= 17'h0_0001;
      frac_acc_q <= 4'h0;
      samp_tick_q <= 1'b0;
    end else begin
      samp_tick_q <= gen_end;
      if (gen_end) begin
        gen_cnt_q <= gen_reload;
        frac_acc_q <= frac_sum[3:0];
      end else if (pre_tick) begin
        gen_cnt_q <= gen_cnt_q - 17'h0_0001;
      end
    end
  end

  // FIFO occupancy.
  wire fifo_empty = (wr_ptr_q == rd_ptr_q);
  wire fifo_full = (wr_ptr_q[PTR_W] != rd_ptr_q[PTR_W])
      && (wr_ptr_q[PTR_W-1:0] == rd_ptr_q[PTR_W-1:0]);
  // Writes to a full FIFO are dropped; the host checks bit 5 first.
  wire push = wr_hold && !fifo_full;
  wire [7:0] fifo_head = fifo_mem[rd_ptr_q[PTR_W-1:0]];

  // Bit timing: a bit ends on the last sampling tick of its period.
  wire bit_end = samp_tick_q && (tick_cnt_q == (tpb - 5'h01));
  wire [3:0] wlen = fbg_pkg::WLEN_BASE
      + {2'b00, line_ctrl_q[fbg_pkg::LCR_WLEN_LSB +: 2]};
  wire par_en = line_ctrl_q[fbg_pkg::LCR_PAR_EN_BIT];
  wire par_even = line_ctrl_q[fbg_pkg::LCR_PAR_EVEN_BIT];
  wire [3:0] stop_bits = line_ctrl_q[fbg_pkg::LCR_STOP_BIT] ? 4'h2 : 4'h1;
  // A frame may start only on a sampling tick, so bit edges stay aligned.
  wire start_idle = (state_q == fbg_pkg::TX_IDLE) && samp_tick_q
      && !fifo_empty;
  wire stop_done = (state_q == fbg_pkg::TX_STOP) && bit_end
      && (bit_idx_q == stop_bits - 4'h1);
  wire load = start_idle || (stop_done && !fifo_empty);
  wire pop = load;

  // Transmit sequencer.
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_idx_d = bit_idx_q;
    parity_d = parity_q;
    txd_d = txd_q;
    case (state_q)
      fbg_pkg::TX_IDLE: begin
        txd_d = 1'b1;
      end
      fbg_pkg::TX_START: begin
        if (bit_end) begin
          state_d = fbg_pkg::TX_DATA;
          txd_d = shift_q[0];
          parity_d = shift_q[0];
          shift_d = {1'b0, shift_q[7:1]};
          bit_idx_d = 4'h0;
        end
      end
      fbg_pkg::TX_DATA: begin
        if (bit_end) begin
          if (bit_idx_q == wlen - 4'h1) begin
            bit_idx_d = 4'h0;
            if (par_en) begin
              state_d = fbg_pkg::TX_PARITY;
              txd_d = par_even ? parity_q : !parity_q;
            end else begin
              state_d = fbg_pkg::TX_STOP;
              txd_d = 1'b1;
            end
          end else begin
            bit_idx_d = bit_idx_q + 4'h1;
            txd_d = shift_q[0];
            parity_d = parity_q ^ shift_q[0];
            shift_d = {1'b0, shift_q[7:1]};
          end
        end
      end
      fbg_pkg::TX_PARITY: begin
        if (bit_end) begin
          state_d = fbg_pkg::TX_STOP;
          txd_d = 1'b1;
          bit_idx_d = 4'h0;
        end
      end
      fbg_pkg::TX_STOP: begin
        if (bit_end) begin
          if (bit_idx_q == stop_bits - 4'h1) begin
            state_d = fbg_pkg::TX_IDLE;
            txd_d = 1'b1;
          end else begin
            bit_idx_d = bit_idx_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = fbg_pkg::TX_IDLE;
        txd_d = 1'b1;
      end
    endcase
    // Loading overrides: a new frame begins with its start bit.
    if (load) begin
      state_d = fbg_pkg::TX_START;
      shift_d = fifo_head;
      txd_d = 1'b0;
      bit_idx_d = 4'h0;
    end
  end

  // Sequencer registers; the tick counter restarts with every bit.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= fbg_pkg::TX_IDLE;
      shift_q <= 8'h00;
      bit_idx_q <= 4'h0;
      parity_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_idx_q <= bit_idx_d;
      parity_q <= parity_d;
      txd_q <= txd_d;
    end
  end

  // Sampling ticks within the current bit.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt_q <= 5'h00;
    end else if (load || bit_end) begin
      tick_cnt_q <= 5'h00;
    end else if (samp_tick_q) begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
    end
  end

  // FIFO storage has no reset; the pointers define what is valid.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      fifo_mem[wr_ptr_q[PTR_W-1:0]] <= wr_data_in;
    end
  end

  // FIFO pointers.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  // Line status: bit 5 holding side empty, bit 6 shifter empty as well.
  wire hold_empty = fifo_empty;
  wire all_empty = fifo_empty && (state_q == fbg_pkg::TX_IDLE);
  logic [7:0] line_status;
  always_comb begin
    line_status = 8'h00;
    line_status[fbg_pkg::STAT_HOLD_EMPTY_BIT] = hold_empty;
    line_status[fbg_pkg::STAT_TX_EMPTY_BIT] = all_empty;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_empty_q <= 1'b1;
    end else begin
      tx_empty_q <= all_empty;
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_low_q <= fbg_pkg::RST_DIV_LOW;
      div_high_q <= fbg_pkg::RST_DIV_HIGH;
      div_frac_q <= fbg_pkg::RST_DIV_FRAC;
      modem_ctrl_q <= fbg_pkg::RST_MODEM_CTRL;
      line_ctrl_q <= fbg_pkg::RST_LINE_CTRL;
    end else begin
      if (wr_low) begin
        div_low_q <= wr_data_in;
      end
      if (wr_high) begin
        div_high_q <= wr_data_in;
      end
      if (wr_frac) begin
        div_frac_q <= wr_data_in;
      end
      if (wr_modem) begin
        modem_ctrl_q <= wr_data_in;
      end
      if (wr_lcr) begin
        line_ctrl_q <= wr_data_in;
      end
    end
  end

  // Read mux; the holding register is write only and reads as zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (addr_in)
      fbg_pkg::OFS_DIV_LOW: rd_mux = div_low_q;
      fbg_pkg::OFS_DIV_HIGH: rd_mux = div_high_q;
      fbg_pkg::OFS_DIV_FRAC: rd_mux = div_frac_q;
      fbg_pkg::OFS_MODEM_CTRL: rd_mux = modem_ctrl_q;
      fbg_pkg::OFS_LINE_CTRL: rd_mux = line_ctrl_q;
      fbg_pkg::OFS_LINE_STATUS: rd_mux = line_status;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_q <= 8'h00;
    end else if (rd_en_in) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  assign rd_data_out = rd_data_q;
  assign txd_out = txd_q;
  assign sample_tick_out = samp_tick_q;
  assign tx_empty_out = tx_empty_q;

endmodule
